// [verilog/mcg_pkg.sv]
/*
 Constants for the clock generation block: register addresses, field
 positions, reset values, oscillator source codes and nominal rates.
 Assumes an 8-bit special function register port on the core side.
*/
package mcg_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [7:0] MCG_ADDR_DIVIDER = 8'h95;
   localparam logic [7:0] MCG_ADDR_TUNE = 8'h96;
   localparam logic [7:0] MCG_ADDR_AUX = 8'ha2;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int MCG_TUNE_W = 6;
   localparam int MCG_TUNE_CLKOUT_BIT = 6;
   localparam int MCG_AUX_LOWPWR_BIT = 7;
   localparam logic [7:0] MCG_DIVIDER_RESET = 8'h00;
   localparam logic MCG_LOWPWR_RESET = 1'b0;
   localparam logic MCG_CLKOUT_RESET = 1'b0;
   localparam logic [7:0] MCG_UNMAPPED_READ = 8'h00;

   // ****************************************
   // Oscillator source selection codes
   // ****************************************
   typedef enum logic [2:0] {
      MCG_SRC_RC = 3'h0,
      MCG_SRC_WDOG = 3'h1,
      MCG_SRC_XTAL_LOW = 3'h2,
      MCG_SRC_XTAL_MED = 3'h3,
      MCG_SRC_XTAL_HIGH = 3'h4,
      MCG_SRC_EXTERNAL = 3'h5
   } mcg_src_type;

   // ****************************************
   // Clock output sequencer states, gray along the cycle except the step from LOW back to IDLE
   // ****************************************
   typedef enum logic [1:0] {
      MCG_CKO_IDLE = 2'b00,
      MCG_CKO_HIGH = 2'b01,
      MCG_CKO_LOW = 2'b11
   } mcg_cko_type;

   // ****************************************
   // Nominal rates and fixed ratios
   // ****************************************
   localparam int MCG_RC_NOMINAL_KHZ = 7373;
   localparam int MCG_WDOG_NOMINAL_KHZ = 400;
   localparam int MCG_CPU_PER_MACHINE = 2;
   localparam int MCG_CPU_PER_PERIPH = 2;
   localparam int MCG_DIV_CNT_W = 9;

endpackage : mcg_pkg

// [verilog/mcg_clock_gen.sv]
/*
 Clock generation for a small 8-bit controller: source select, divide-by-M
 CPU clock, peripheral and machine cycle ticks, clock output pin and the
 RC tune register.
 Assumes oscillator inputs are slow against clk and sampled here; derived
 clocks leave as one-cycle enable ticks on clk, not as gated clocks.
*/
// Contract
// - Machine cycle equals two CPU clocks
// - Selected oscillator feeds divider, gives CPU clock
// - Peripheral clock is CPU clock over two
// - RC oscillator nominal 7.373 MHz is selectable
// - Source chosen by nonvolatile configuration bits
// - Low power access bit resets to zero
// - Clock output only without crystal in use
// - Clock output runs at half CPU clock
// - Six-bit writable RC tune field
// - Only power-on reset loads tune value
// - Watchdog oscillator 400 kHz is selectable
// - External clock on crystal input pin
// - Divider register at 95H, resets to 00
`timescale 1ns/10ps
`default_nettype none

module mcg_clock_gen #(
   parameter logic [5:0] TUNE_FACTORY = 6'h20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic por_rst,
   input wire mcg_pkg::mcg_src_type osc_source_cfg,
   input wire logic rtc_uses_crystal,
   input wire logic rc_osc_clock,
   input wire logic wdog_osc_clock,
   input wire logic crystal_input_pin,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   output logic selected_osc_clock,
   output logic cpu_core_clock,
   output logic periph_clock,
   output logic machine_cycle,
   output logic [5:0] rc_tune,
   output logic low_power_clock_access,
   output logic crystal_osc_enable,
   output logic crystal_output_pin_out,
   output logic crystal_output_pin_oe
);
   import mcg_pkg::*;

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction : rise

   function automatic logic crystal_mode(input mcg_src_type s);
      crystal_mode = (s == MCG_SRC_XTAL_LOW) || (s == MCG_SRC_XTAL_MED) ||
                     (s == MCG_SRC_XTAL_HIGH);
   endfunction : crystal_mode

   // ****************************************
   // Resets
   // ****************************************
   // Power-on also clears the ordinary registers
   wire logic any_rst;
   assign any_rst = rst | por_rst;

   // ****************************************
   // Source selection
   // ****************************************
   // Configuration picks source
   wire logic raw_osc;
   assign raw_osc = (osc_source_cfg == MCG_SRC_RC) ? rc_osc_clock :
                    (osc_source_cfg == MCG_SRC_WDOG) ? wdog_osc_clock :
                    crystal_input_pin;
   assign crystal_osc_enable = crystal_mode(osc_source_cfg);

   // ****************************************
   // Oscillator synchroniser and edge detect
   // ****************************************
   // Source may switch only with configuration, so one sync chain suffices
   logic osc_meta;
   logic osc_sync;
   logic osc_prev;
   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_meta <= raw_osc;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   wire logic osc_tick;
   assign osc_tick = rise(osc_sync, osc_prev);
   assign selected_osc_clock = osc_tick;

   // ****************************************
   // Register decode
   // ****************************************
   wire logic sel_div;
   wire logic sel_tune;
   wire logic sel_aux;
   assign sel_div = (sfr_addr == MCG_ADDR_DIVIDER);
   assign sel_tune = (sfr_addr == MCG_ADDR_TUNE);
   assign sel_aux = (sfr_addr == MCG_ADDR_AUX);
   assign sfr_hit = sel_div | sel_tune | sel_aux;

   // ****************************************
   // Divider register
   // ****************************************
   logic [7:0] clock_divider_register;
   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         clock_divider_register <= MCG_DIVIDER_RESET;
      end else if (sfr_wr && sel_div) begin
         clock_divider_register <= sfr_wdata;
      end
   end

   // ****************************************
   // Tune register, power-on reset only
   // ****************************************
   logic [5:0] tune;
   logic clock_out_enable;
   always_ff @(posedge clk or posedge por_rst) begin
      if (por_rst) begin
         tune <= TUNE_FACTORY;
         clock_out_enable <= MCG_CLKOUT_RESET;
      end else if (sfr_wr && sel_tune) begin
         tune <= sfr_wdata[MCG_TUNE_W-1:0];
         clock_out_enable <= sfr_wdata[MCG_TUNE_CLKOUT_BIT];
      end
   end
   assign rc_tune = tune;

   // ****************************************
   // Auxiliary register, low power access bit
   // ****************************************
   logic lowpwr;
   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         lowpwr <= MCG_LOWPWR_RESET;
      end else if (sfr_wr && sel_aux) begin
         lowpwr <= sfr_wdata[MCG_AUX_LOWPWR_BIT];
      end
   end
   // Only a hint to the memory timing; no check against the real rate
   assign low_power_clock_access = lowpwr;

   // ****************************************
   // Read data
   // ****************************************
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = MCG_UNMAPPED_READ;
      if (sel_div) begin
         next_rdata = clock_divider_register;
      end else if (sel_tune) begin
         next_rdata[MCG_TUNE_W-1:0] = tune;
         next_rdata[MCG_TUNE_CLKOUT_BIT] = clock_out_enable;
      end else if (sel_aux) begin
         next_rdata[MCG_AUX_LOWPWR_BIT] = lowpwr;
      end
   end

   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         sfr_rdata <= MCG_UNMAPPED_READ;
      end else if (sfr_rd) begin
         sfr_rdata <= next_rdata;
      end
   end

   // ****************************************
   // Divide-by-M CPU clock
   // ****************************************
   // CPU clock is the oscillator over 2*M; M of zero passes it straight
   logic [MCG_DIV_CNT_W-1:0] div_cnt;
   wire logic [MCG_DIV_CNT_W-1:0] div_last;
   wire logic div_bypass;
   wire logic div_wrap;
   wire logic cpu_tick;
   assign div_last = MCG_DIV_CNT_W'({clock_divider_register, 1'b0} - 9'h001);
   assign div_bypass = (clock_divider_register == 8'h00);
   assign div_wrap = (div_cnt >= div_last);
   assign cpu_tick = osc_tick & (div_bypass | div_wrap);

   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         div_cnt <= '0;
      end else if (osc_tick) begin
         div_cnt <= (div_bypass || div_wrap) ? '0 : div_cnt + 9'h001;
      end
   end
   assign cpu_core_clock = cpu_tick;

   // ****************************************
   // Peripheral clock and machine cycle
   // ****************************************
   logic cpu_phase;
   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         cpu_phase <= 1'b0;
      end else if (cpu_tick) begin
         cpu_phase <= ~cpu_phase;
      end
   end
   // Peripheral tick every second CPU clock
   assign periph_clock = cpu_tick & cpu_phase;
   // Machine cycle is two CPU clocks
   assign machine_cycle = cpu_tick & cpu_phase;

   // ****************************************
   // Clock output pin
   // ****************************************
   // Output needs crystal unused
   wire logic cko_allowed;
   wire logic cko_request;
   assign cko_allowed = ~crystal_mode(osc_source_cfg) & ~rtc_uses_crystal;
   assign cko_request = cko_allowed & clock_out_enable;

   mcg_cko_type cko_state;
   mcg_cko_type next_cko_state;
   // Start and stop on CPU edges; a blocked output parks at once
   always_comb begin
      next_cko_state = cko_state;
      case (cko_state)
         MCG_CKO_IDLE: begin
            if (cpu_tick && cko_request) begin
               next_cko_state = MCG_CKO_HIGH;
            end
         end
         MCG_CKO_HIGH: begin
            if (cpu_tick) begin
               next_cko_state = MCG_CKO_LOW;
            end
         end
         MCG_CKO_LOW: begin
            if (cpu_tick) begin
               next_cko_state = cko_request ? MCG_CKO_HIGH : MCG_CKO_IDLE;
            end
         end
         default: begin
            next_cko_state = MCG_CKO_IDLE;
         end
      endcase
      // Park when blocked
      // Parking at once keeps the pin from toggling while released
      if (!cko_allowed) begin
         next_cko_state = MCG_CKO_IDLE;
      end
   end

   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         cko_state <= MCG_CKO_IDLE;
      end else begin
         cko_state <= next_cko_state;
      end
   end

   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         crystal_output_pin_out <= 1'b0;
      end else begin
         crystal_output_pin_out <= (next_cko_state == MCG_CKO_HIGH);
      end
   end

   always_ff @(posedge clk or posedge any_rst) begin
      if (any_rst) begin
         crystal_output_pin_oe <= 1'b0;
      end else begin
         crystal_output_pin_oe <= cko_allowed &
                                  (next_cko_state != MCG_CKO_IDLE);
      end
   end

endmodule : mcg_clock_gen

`default_nettype wire

// [testbench/mcg_xtal_model.sv]
/*
 Model of the crystal or external clock source on the crystal input pin.
 Assumes the bench drives the configured source code on mode.
*/
`timescale 1ns/10ps
`default_nettype none
module mcg_xtal_model #(
   parameter int HALF_LOW_NS = 6000,
   parameter int HALF_MED_NS = 130,
   parameter int HALF_HIGH_NS = 50
) (
   input wire mcg_pkg::mcg_src_type mode,
   output logic xin
);
   import mcg_pkg::*;
   // ****************
   // Source waveform
   // ****************
   // rate within chosen range
   // external rate up to 18 MHz
   // Held low when off, so no stray edges
   initial xin = 1'b0;
   always begin
      case (mode)
         MCG_SRC_XTAL_LOW: #HALF_LOW_NS;
         MCG_SRC_XTAL_HIGH: #HALF_HIGH_NS;
         default: #HALF_MED_NS;
      endcase
      xin = (mode >= MCG_SRC_XTAL_LOW) ? ~xin : 1'b0;
   end
endmodule : mcg_xtal_model
`default_nettype wire

// [testbench/mcg_clock_gen_assertions.sv]
/*
 Checker for the clock generation block.
 Assumes one clk domain; both resets quiet the checks, except a_tune_keeps, which only power-on reset quiets.
*/
`timescale 1ns/10ps
`default_nettype none
module mcg_clock_gen_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic por_rst,
   input wire mcg_pkg::mcg_src_type osc_source_cfg,
   input wire logic rtc_uses_crystal,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic selected_osc_clock,
   input wire logic cpu_core_clock,
   input wire logic periph_clock,
   input wire logic machine_cycle,
   input wire logic [5:0] rc_tune,
   input wire logic low_power_clock_access,
   input wire logic crystal_osc_enable,
   input wire logic crystal_output_pin_out,
   input wire logic crystal_output_pin_oe
);
   import mcg_pkg::*;
   // ****************
   // Properties
   // ****************
   // Cpu ticks since the last machine cycle tick
   logic [1:0] cpu_since_mc;
   always_ff @(posedge clk or posedge rst or posedge por_rst) begin
      if (rst || por_rst) begin
         cpu_since_mc <= 2'h0;
      end else if (machine_cycle) begin
         cpu_since_mc <= 2'h0;
      end else if (cpu_core_clock && cpu_since_mc != 2'h3) begin
         cpu_since_mc <= cpu_since_mc + 2'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst || por_rst);
   a_machine_even: assert property (cpu_core_clock |->
      machine_cycle == (cpu_since_mc == 2'h1))
      else $error("machine cycle not every second cpu tick");
   a_periph_on_cpu: assert property (periph_clock |-> cpu_core_clock)
      else $error("peripheral tick without cpu tick");
   a_machine_pairs: assert property (machine_cycle == periph_clock)
      else $error("machine cycle tick misplaced");
   a_cpu_on_osc: assert property (cpu_core_clock |-> selected_osc_clock)
      else $error("cpu tick without oscillator tick");
   a_xtal_modes: assert property (crystal_osc_enable ==
      (osc_source_cfg inside {MCG_SRC_XTAL_LOW, MCG_SRC_XTAL_MED,
      MCG_SRC_XTAL_HIGH})) else $error("crystal enable wrong");
   a_cko_blocked: assert property ((crystal_osc_enable ||
      rtc_uses_crystal) |=> !crystal_output_pin_oe)
      else $error("clock out driven while blocked");
   a_cko_cadence: assert property (crystal_output_pin_oe &&
      $past(crystal_output_pin_oe) |-> $changed(crystal_output_pin_out)
      == $past(cpu_core_clock)) else $error("clock out off cadence");
   a_cko_idle_low: assert property (!crystal_output_pin_oe |->
      !crystal_output_pin_out) else $error("clock out not low when idle");
   a_lowpwr_write: assert property (sfr_wr && sfr_addr == 8'ha2 |=>
      low_power_clock_access == ($past(sfr_wdata) >= 8'h80))
      else $error("low power bit not written");
   a_tune_write: assert property (sfr_wr && sfr_addr == 8'h96 |=>
      {2'h0, rc_tune} == ($past(sfr_wdata) & 8'h3f))
      else $error("tune not written");
   a_tune_keeps: assert property (disable iff (por_rst)
      !$past(sfr_wr) |-> $stable(rc_tune)) else $error("tune lost");
endmodule : mcg_clock_gen_checker
bind mcg_clock_gen mcg_clock_gen_checker i_mcg_clock_gen_checker (
   .clk(clk), .rst(rst), .por_rst(por_rst),
   .osc_source_cfg(osc_source_cfg), .rtc_uses_crystal(rtc_uses_crystal),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
   .selected_osc_clock(selected_osc_clock),
   .cpu_core_clock(cpu_core_clock), .periph_clock(periph_clock),
   .machine_cycle(machine_cycle), .rc_tune(rc_tune),
   .low_power_clock_access(low_power_clock_access),
   .crystal_osc_enable(crystal_osc_enable),
   .crystal_output_pin_out(crystal_output_pin_out),
   .crystal_output_pin_oe(crystal_output_pin_oe));
`default_nettype wire

// [testbench/test_mcg_clock_gen.sv]
/*
 Self-checking bench for the clock generation block.
 Assumes the crystal source model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module test_mcg_clock_gen;
   import mcg_pkg::*;
   logic clk, rst, por, rtc, wr_s, rd_s, rco, wdo, xin;
   mcg_src_type src;
   logic [7:0] adr, wd, rdat, got;
   logic [5:0] tune;
   logic sel, cpu, per, mc, lp, xen, pout, poe, hit;
   int n_errors = 0, comparisons = 0, cycles = 0;
   logic [23:0] rows [7] = '{24'h95ffff, 24'h96ff7f, 24'ha2ff80,
      24'h40ff00, 24'ha20000, 24'h960a0a, 24'h950000};
   mcg_xtal_model i_mcg_xtal_model (.mode(src), .xin(xin));
   mcg_clock_gen #(.TUNE_FACTORY(6'h15)) i_mcg_clock_gen (.clk(clk),
      .rst(rst), .por_rst(por), .osc_source_cfg(src),
      .rtc_uses_crystal(rtc), .rc_osc_clock(rco), .wdog_osc_clock(wdo),
      .crystal_input_pin(xin), .sfr_addr(adr), .sfr_wr(wr_s),
      .sfr_rd(rd_s), .sfr_wdata(wd), .sfr_rdata(rdat), .sfr_hit(hit),
      .selected_osc_clock(sel), .cpu_core_clock(cpu), .periph_clock(per),
      .machine_cycle(mc), .rc_tune(tune), .low_power_clock_access(lp),
      .crystal_osc_enable(xen), .crystal_output_pin_out(pout),
      .crystal_output_pin_oe(poe));
   // ****************
   // Clocks and tasks
   // ****************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always #30 rco = ~rco;
   always #50 wdo = ~wdo;
   // Ceiling well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict;
      end
   end
   task check(input logic [7:0] g, e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, g, e);
      end
   endtask : check
   task wr(input logic [7:0] a, d);
      @(negedge clk);
      adr = a;
      wd = d;
      wr_s = 1'b1;
      @(negedge clk);
      wr_s = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(negedge clk);
      adr = a;
      rd_s = 1'b1;
      @(negedge clk);
      rd_s = 1'b0;
      got = rdat;
   endtask : rd
   task boot(input mcg_src_type s, input logic p);
      @(negedge clk);
      src = s;
      rst = 1'b1;
      por = p;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      por = 1'b0;
      repeat (3) @(negedge clk);
   endtask : boot
   task ratio(input mcg_src_type s, input logic [7:0] m, e);
      int k, no, nc, np, nm;
      k = 0;
      no = 0;
      nc = 0;
      np = 0;
      nm = 0;
      boot(s, 1'b0);
      check({7'h0, xen}, {7'h0, s inside {[2:4]}});
      wr(8'h95, m);
      while (per !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      while (no < 16 && k < 2000) begin
         @(negedge clk);
         k++;
         no += sel;
         nc += cpu;
         np += per;
         nm += mc;
      end
      check(8'(nc), e);
      check(8'(np), e / 2);
      check(8'(nm), e / 2);
   endtask : ratio
   task oe_is(input logic v);
      int k;
      k = 0;
      while (poe !== v && k < 300) begin
         @(negedge clk);
         k++;
      end
      check({7'h0, poe}, {7'h0, v});
   endtask : oe_is
   task print_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // ****************
   // Sequence
   // ****************
   initial begin
      {rst, por, rtc, wr_s, rd_s, rco, wdo} = 7'h60;
      src = MCG_SRC_RC;
      adr = 8'h00;
      wd = 8'h00;
      repeat (3) @(negedge clk);
      {rst, por} = 2'h0;
      rd(8'h95);
      check(got, 8'h00);
      rd(8'h96);
      check(got, 8'h15);
      rd(8'ha2);
      check(got, 8'h00);
      for (int i = 0; i < 7; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         check(got, rows[i][7:0]);
         check({7'h0, hit}, {7'h0, rows[i][23:16] != 8'h40});
      end
      wr(8'ha2, 8'h80);
      check({7'h0, lp}, 8'h01);
      boot(MCG_SRC_RC, 1'b0);
      check({7'h0, lp}, 8'h00);
      rd(8'h96);
      check(got, 8'h0a);
      check({2'h0, tune}, 8'h0a);
      boot(MCG_SRC_RC, 1'b1);
      rd(8'h96);
      check(got, 8'h15);
      check({2'h0, tune}, 8'h15);
      ratio(MCG_SRC_RC, 8'h01, 8'h08);
      ratio(MCG_SRC_WDOG, 8'h00, 8'h10);
      ratio(MCG_SRC_XTAL_MED, 8'h02, 8'h04);
      ratio(MCG_SRC_EXTERNAL, 8'h01, 8'h08);
      wr(8'h96, 8'h55);
      oe_is(1'b1);
      rtc = 1'b1;
      oe_is(1'b0);
      rtc = 1'b0;
      oe_is(1'b1);
      wr(8'h96, 8'h15);
      oe_is(1'b0);
      check({7'h0, pout}, 8'h00);
      // Low range last: its slow crystal would stall later ratio runs
      for (int j = 0; j < 2; j++) begin
         boot(j ? MCG_SRC_XTAL_LOW : MCG_SRC_XTAL_HIGH, 1'b0);
         wr(8'h96, 8'h55);
         repeat (60) @(negedge clk);
         check({7'h0, poe}, 8'h00);
         check({7'h0, xen}, 8'h01);
      end
      print_verdict;
   end
endmodule : test_mcg_clock_gen
`default_nettype wire
